// File: inc/gpwm_map.vh
// Register indices, field positions and reset values of the port
`ifndef GPWM_MAP_VH
`define GPWM_MAP_VH

// ----------------------------------------
// Register indices (byte address is index times four)
// ----------------------------------------
`define GPWM_IDX_IN_HIGH 16'h4700
`define GPWM_IDX_IN_LOW 16'h4702
`define GPWM_IDX_OUT_HIGH 16'h4704
`define GPWM_IDX_OUT_LOW 16'h4706
`define GPWM_IDX_OSET_HIGH 16'h4708
`define GPWM_IDX_OSET_LOW 16'h470A
`define GPWM_IDX_OCLR_HIGH 16'h470C
`define GPWM_IDX_OCLR_LOW 16'h470E
`define GPWM_IDX_DEBUG 16'h4710
`define GPWM_IDX_ROUTING 16'h4712
`define GPWM_IDX_DRV_HIGH 16'h4714
`define GPWM_IDX_DRV_LOW 16'h4716
`define GPWM_IDX_DSET_HIGH 16'h4718
`define GPWM_IDX_DSET_LOW 16'h471A
`define GPWM_IDX_DCLR_HIGH 16'h471C
`define GPWM_IDX_DCLR_LOW 16'h471E
`define GPWM_IDX_PU_HIGH 16'h4720
`define GPWM_IDX_PU_LOW 16'h4722
`define GPWM_IDX_PD_HIGH 16'h4724
`define GPWM_IDX_PD_LOW 16'h4726
`define GPWM_IDX_WAKE_MASK 16'h4728
`define GPWM_IDX_FREEZE 16'h472A
`define GPWM_IDX_ACTIVITY 16'h472C
`define GPWM_IDX_CMP_ROUTE 16'h472E

// ----------------------------------------
// Routing reset value and write mask
// ----------------------------------------
`define GPWM_ROUTING_RST 16'h2000
`define GPWM_ROUTING_WMASK 16'h7FFF

// ----------------------------------------
// Routing field positions
// ----------------------------------------
`define GPWM_RT_TRACE 14
`define GPWM_RT_PIN4_HI 13
`define GPWM_RT_PIN4_LO 12
`define GPWM_RT_PIN5_HI 11
`define GPWM_RT_PIN5_LO 10
`define GPWM_RT_PIN6 9
`define GPWM_RT_PIN7_HI 8
`define GPWM_RT_PIN7_LO 7
`define GPWM_RT_PIN8 6
`define GPWM_RT_SER_HI 3
`define GPWM_RT_SER_LO 0
`define GPWM_ANALOG_CODE 2'h1

`endif

// File: rtl/gpwm_port.v
// Seventeen-pin general-purpose port with routing, freeze and activity monitor
//
// Summary of operation
// - Seventeen pins, each input, output or both
// - Push-pull drive; open-drain via drive-enable toggling
// - Per-pin pull-up and pull-down enable registers
// - Input registers return sampled pin levels
// - Drive-enable one turns pin driver on
// - Set registers force written ones high
// - Clear registers force written ones low
// - Output, set, clear reads return stored value
// - Pin control registers keep contents until system reset
// - Routing register resets to plain port pattern
// - One routing bit connects trace pins
// - Pins four to eight analog, regulator, reference
// - Four-bit code picks serial and capture sets
// - Capture inputs taken from code-selected pins
// - Deep sleep holds pin outputs frozen
// - Level change on monitored pins raises activity
// - Wake mask selects monitored lowest sixteen pins
// - Activity event drives wake request
//
// Our own choices: the APB slave port and the register offsets.
`include "gpwm_map.vh"

module gpwm_port (
    // Clock and reset
    input wire clk_sys,
    input wire sys_rst,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [19:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // Pads
    input wire [16:0] pad_in,
    output reg [16:0] pad_out,
    output reg [16:0] pad_oe,
    output reg [16:0] pad_pullup,
    output reg [16:0] pad_pulldown,
    // Power control
    input wire deep_sleep,
    output reg wake_req,
    // Alternate sources
    input wire trace_frame_enable,
    input wire trace_serial_out,
    input wire regulator_enable,
    input wire vref_drive,
    input wire [7:0] serial_dout,
    input wire [7:0] serial_doe,
    input wire timer_b_compare_out_a,
    input wire timer_b_compare_out_b,
    input wire timer_a_compare_out_a,
    input wire timer_a_compare_out_b,
    // Alternate sinks
    output reg [3:0] analog_in_sel,
    output reg vref_out_en,
    output reg [7:0] serial_din,
    output reg timer_a_cap_a,
    output reg timer_a_cap_b,
    output reg timer_b_cap_a,
    output reg timer_b_cap_b
);

// ----------------------------------------
// Registers
// ----------------------------------------
reg [16:0] out_reg;
reg [16:0] drive_reg;
reg [16:0] pullup_reg;
reg [16:0] pulldown_reg;
reg [15:0] debug_reg;
reg [15:0] routing_reg;
reg [15:0] wake_mask_reg;
reg freeze_reg;
reg activity_reg;
reg [3:0] cmp_route_reg;
reg [16:0] sync1_reg;
reg [16:0] sync2_reg;
reg [16:0] sync3_reg;
reg [16:0] level_reg;
reg [2:0] sleep_sync_reg;
reg sleep_reg;

// ----------------------------------------
// Bus decode
// ----------------------------------------
wire [15:0] idx = paddr[17:2];
wire aligned = (paddr[1:0] == 2'h0) && (paddr[19:18] == 2'h0);
wire setup = psel && !penable;
wire wr = psel && penable && pwrite && pready;
wire [16:0] wdata_high = {pwdata[0], 16'h0000};
wire [16:0] wdata_low = {1'b0, pwdata[15:0]};
reg [31:0] rdata_next;
reg mapped_next;

always @* begin
    rdata_next = 32'h0000_0000;
    mapped_next = aligned;
    case (idx)
        `GPWM_IDX_IN_HIGH: rdata_next = {31'h0, level_reg[16]};
        `GPWM_IDX_IN_LOW: rdata_next = {16'h0, level_reg[15:0]};
        `GPWM_IDX_OUT_HIGH, `GPWM_IDX_OSET_HIGH, `GPWM_IDX_OCLR_HIGH:
            rdata_next = {31'h0, out_reg[16]};
        `GPWM_IDX_OUT_LOW, `GPWM_IDX_OSET_LOW, `GPWM_IDX_OCLR_LOW:
            rdata_next = {16'h0, out_reg[15:0]};
        `GPWM_IDX_DRV_HIGH, `GPWM_IDX_DSET_HIGH, `GPWM_IDX_DCLR_HIGH:
            rdata_next = {31'h0, drive_reg[16]};
        `GPWM_IDX_DRV_LOW, `GPWM_IDX_DSET_LOW, `GPWM_IDX_DCLR_LOW:
            rdata_next = {16'h0, drive_reg[15:0]};
        `GPWM_IDX_PU_HIGH: rdata_next = {31'h0, pullup_reg[16]};
        `GPWM_IDX_PU_LOW: rdata_next = {16'h0, pullup_reg[15:0]};
        `GPWM_IDX_PD_HIGH: rdata_next = {31'h0, pulldown_reg[16]};
        `GPWM_IDX_PD_LOW: rdata_next = {16'h0, pulldown_reg[15:0]};
        `GPWM_IDX_DEBUG: rdata_next = {16'h0, debug_reg};
        `GPWM_IDX_ROUTING: rdata_next = {16'h0, routing_reg};
        `GPWM_IDX_WAKE_MASK: rdata_next = {16'h0, wake_mask_reg};
        `GPWM_IDX_FREEZE: rdata_next = {30'h0, sleep_reg, freeze_reg};
        `GPWM_IDX_ACTIVITY: rdata_next = {31'h0, activity_reg};
        `GPWM_IDX_CMP_ROUTE: rdata_next = {28'h0, cmp_route_reg};
        default: mapped_next = 1'b0;
    endcase
    if (!mapped_next) begin
        rdata_next = 32'h0000_0000;
    end
end

// ----------------------------------------
// APB answer, one access cycle
// ----------------------------------------
always @(posedge clk_sys) begin
    if (sys_rst) begin
        pready <= 1'b0;
        pslverr <= 1'b0;
        prdata <= 32'h0000_0000;
    end else begin
        pready <= setup;
        pslverr <= setup && !mapped_next;
        prdata <= (setup && !pwrite) ? rdata_next : 32'h0000_0000;
    end
end

// ----------------------------------------
// Control registers, reset only by system reset
// ----------------------------------------
wire wr_ok = wr && !pslverr;
wire activity_event;

always @(posedge clk_sys) begin
    if (sys_rst) begin
        out_reg <= 17'h00000;
        drive_reg <= 17'h00000;
        pullup_reg <= 17'h00000;
        pulldown_reg <= 17'h00000;
        debug_reg <= 16'h0000;
        routing_reg <= `GPWM_ROUTING_RST;
        wake_mask_reg <= 16'h0000;
        freeze_reg <= 1'b0;
        cmp_route_reg <= 4'h0;
        activity_reg <= 1'b0;
    end else begin
        if (wr_ok) begin
            case (idx)
                `GPWM_IDX_OUT_HIGH: out_reg[16] <= pwdata[0];
                `GPWM_IDX_OUT_LOW: out_reg[15:0] <= pwdata[15:0];
                `GPWM_IDX_OSET_HIGH: out_reg <= out_reg | wdata_high;
                `GPWM_IDX_OSET_LOW: out_reg <= out_reg | wdata_low;
                `GPWM_IDX_OCLR_HIGH: out_reg <= out_reg & ~wdata_high;
                `GPWM_IDX_OCLR_LOW: out_reg <= out_reg & ~wdata_low;
                `GPWM_IDX_DRV_HIGH: drive_reg[16] <= pwdata[0];
                `GPWM_IDX_DRV_LOW: drive_reg[15:0] <= pwdata[15:0];
                `GPWM_IDX_DSET_HIGH: drive_reg <= drive_reg | wdata_high;
                `GPWM_IDX_DSET_LOW: drive_reg <= drive_reg | wdata_low;
                `GPWM_IDX_DCLR_HIGH: drive_reg <= drive_reg & ~wdata_high;
                `GPWM_IDX_DCLR_LOW: drive_reg <= drive_reg & ~wdata_low;
                `GPWM_IDX_PU_HIGH: pullup_reg[16] <= pwdata[0];
                `GPWM_IDX_PU_LOW: pullup_reg[15:0] <= pwdata[15:0];
                `GPWM_IDX_PD_HIGH: pulldown_reg[16] <= pwdata[0];
                `GPWM_IDX_PD_LOW: pulldown_reg[15:0] <= pwdata[15:0];
                `GPWM_IDX_DEBUG: debug_reg <= pwdata[15:0];
                `GPWM_IDX_ROUTING: routing_reg <= pwdata[15:0] & `GPWM_ROUTING_WMASK;
                `GPWM_IDX_WAKE_MASK: wake_mask_reg <= pwdata[15:0];
                `GPWM_IDX_FREEZE: freeze_reg <= pwdata[0];
                `GPWM_IDX_CMP_ROUTE: cmp_route_reg <= pwdata[3:0];
                default: ;
            endcase
        end
        // Set wins over write-one-to-clear
        if (activity_event) begin
            activity_reg <= 1'b1;
        end else if (wr_ok && idx == `GPWM_IDX_ACTIVITY && pwdata[0]) begin
            activity_reg <= 1'b0;
        end
    end
end

// ----------------------------------------
// Pad and sleep synchronisers
// ----------------------------------------
wire [16:0] level_next;
genvar g;
generate
    for (g = 0; g < 17; g = g + 1) begin : g_lvl
        assign level_next[g] = (sync2_reg[g] == sync3_reg[g]) ? sync3_reg[g] : level_reg[g];
    end
endgenerate

always @(posedge clk_sys) begin
    if (sys_rst) begin
        sync1_reg <= 17'h00000;
        sync2_reg <= 17'h00000;
        sync3_reg <= 17'h00000;
        level_reg <= 17'h00000;
        sleep_sync_reg <= 3'h0;
        sleep_reg <= 1'b0;
    end else begin
        sync1_reg <= pad_in;
        sync2_reg <= sync1_reg;
        sync3_reg <= sync2_reg;
        level_reg <= level_next;
        sleep_sync_reg <= {sleep_sync_reg[1:0], deep_sleep};
        if (sleep_sync_reg[1] == sleep_sync_reg[2]) begin
            sleep_reg <= sleep_sync_reg[2];
        end
    end
end

// Monitored pins changing level in the clock domain
assign activity_event = |((level_next[15:0] ^ level_reg[15:0]) & wake_mask_reg);

// ----------------------------------------
// Serial pin availability and capture mode by code
// ----------------------------------------
wire [3:0] ser_code = routing_reg[`GPWM_RT_SER_HI:`GPWM_RT_SER_LO];
reg [7:0] ser_free;
reg [1:0] cap_a_mode;
reg [1:0] cap_b_mode;

always @* begin
    ser_free = 8'hFF;
    cap_a_mode = 2'h0;
    cap_b_mode = 2'h0;
    case (ser_code)
        4'h0: begin ser_free = 8'hFF; cap_b_mode = 2'h0; cap_a_mode = 2'h0; end
        4'h1: begin ser_free = 8'hC9; cap_b_mode = 2'h0; cap_a_mode = 2'h0; end
        4'h2: begin ser_free = 8'h00; cap_b_mode = 2'h2; cap_a_mode = 2'h2; end
        4'h3: begin ser_free = 8'h88; cap_b_mode = 2'h2; cap_a_mode = 2'h2; end
        4'h4: begin ser_free = 8'hF9; cap_b_mode = 2'h0; cap_a_mode = 2'h0; end
        4'h5: begin ser_free = 8'hC0; cap_b_mode = 2'h0; cap_a_mode = 2'h2; end
        4'h6: begin ser_free = 8'h08; cap_b_mode = 2'h2; cap_a_mode = 2'h2; end
        4'h7: begin ser_free = 8'h8F; cap_b_mode = 2'h1; cap_a_mode = 2'h0; end
        4'h8: begin ser_free = 8'hF0; cap_b_mode = 2'h0; cap_a_mode = 2'h1; end
        4'h9: begin ser_free = 8'hC8; cap_b_mode = 2'h0; cap_a_mode = 2'h2; end
        4'hA: begin ser_free = 8'h0F; cap_b_mode = 2'h1; cap_a_mode = 2'h0; end
        4'hB: begin ser_free = 8'h89; cap_b_mode = 2'h2; cap_a_mode = 2'h0; end
        4'hC: begin ser_free = 8'hF8; cap_b_mode = 2'h0; cap_a_mode = 2'h1; end
        4'hD: begin ser_free = 8'hCF; cap_b_mode = 2'h0; cap_a_mode = 2'h0; end
        4'hE: begin ser_free = 8'h09; cap_b_mode = 2'h2; cap_a_mode = 2'h0; end
        default: begin ser_free = 8'h80; cap_b_mode = 2'h2; cap_a_mode = 2'h2; end
    endcase
end

// ----------------------------------------
// Pin function multiplexer
// ----------------------------------------
wire [1:0] pin4_code = routing_reg[`GPWM_RT_PIN4_HI:`GPWM_RT_PIN4_LO];
wire [1:0] pin5_code = routing_reg[`GPWM_RT_PIN5_HI:`GPWM_RT_PIN5_LO];
wire [1:0] pin7_code = routing_reg[`GPWM_RT_PIN7_HI:`GPWM_RT_PIN7_LO];
wire trace_on = routing_reg[`GPWM_RT_TRACE];
wire [3:0] analog_next = {pin7_code == `GPWM_ANALOG_CODE, routing_reg[`GPWM_RT_PIN6],
    pin5_code == `GPWM_ANALOG_CODE, pin4_code == `GPWM_ANALOG_CODE};
reg [16:0] fn_out;
reg [16:0] fn_oe;
reg [16:0] fn_pu;
reg [16:0] fn_pd;
reg [4:0] pin_idx;
integer i;

always @* begin
    fn_out = out_reg;
    fn_oe = drive_reg;
    fn_pu = pullup_reg;
    fn_pd = pulldown_reg;
    pin_idx = 5'h00;
    for (i = 0; i < 8; i = i + 1) begin
        pin_idx = (i < 4) ? i[4:0] : i[4:0] + 5'h05;
        if (!ser_free[i]) begin
            fn_out[pin_idx] = serial_dout[i];
            fn_oe[pin_idx] = serial_doe[i];
        end
    end
    if (trace_on) begin
        fn_out[4] = trace_frame_enable;
        fn_oe[4] = 1'b1;
        fn_out[5] = trace_serial_out;
        fn_oe[5] = 1'b1;
    end
    for (i = 0; i < 4; i = i + 1) begin
        if (analog_next[i]) begin
            fn_oe[i + 4] = 1'b0;
            fn_pu[i + 4] = 1'b0;
            fn_pd[i + 4] = 1'b0;
        end
    end
    if (pin7_code[1]) begin
        fn_out[7] = 1'b0;
        fn_oe[7] = regulator_enable;
    end
    if (routing_reg[`GPWM_RT_PIN8]) begin
        fn_out[8] = vref_drive;
        fn_oe[8] = 1'b1;
    end
    if (cmp_route_reg[0]) begin
        fn_out[13] = timer_b_compare_out_a;
        fn_oe[13] = 1'b1;
    end
    if (cmp_route_reg[1]) begin
        fn_out[14] = timer_b_compare_out_b;
        fn_oe[14] = 1'b1;
    end
    if (cmp_route_reg[2]) begin
        fn_out[15] = timer_a_compare_out_a;
        fn_oe[15] = 1'b1;
    end
    if (cmp_route_reg[3]) begin
        fn_out[16] = timer_a_compare_out_b;
        fn_oe[16] = 1'b1;
    end
end

// ----------------------------------------
// Pad outputs with freeze hold
// ----------------------------------------
wire frozen = freeze_reg || sleep_reg;

always @(posedge clk_sys) begin
    if (sys_rst) begin
        pad_out <= 17'h00000;
        pad_oe <= 17'h00000;
        pad_pullup <= 17'h00000;
        pad_pulldown <= 17'h00000;
        analog_in_sel <= 4'h0;
        vref_out_en <= 1'b0;
        wake_req <= 1'b0;
        serial_din <= 8'h00;
        timer_a_cap_a <= 1'b0;
        timer_a_cap_b <= 1'b0;
        timer_b_cap_a <= 1'b0;
        timer_b_cap_b <= 1'b0;
    end else begin
        if (!frozen) begin
            pad_out <= fn_out;
            pad_oe <= fn_oe;
            pad_pullup <= fn_pu;
            pad_pulldown <= fn_pd;
            analog_in_sel <= analog_next;
            vref_out_en <= routing_reg[`GPWM_RT_PIN8];
        end
        wake_req <= activity_reg;
        serial_din <= {level_reg[12:9], level_reg[3:0]};
        case (cap_a_mode)
            2'h0: begin timer_a_cap_a <= level_reg[0]; timer_a_cap_b <= level_reg[3]; end
            2'h1: begin timer_a_cap_a <= level_reg[9]; timer_a_cap_b <= level_reg[10]; end
            default: begin timer_a_cap_a <= level_reg[13]; timer_a_cap_b <= level_reg[14]; end
        endcase
        case (cap_b_mode)
            2'h0: begin timer_b_cap_a <= level_reg[11]; timer_b_cap_b <= level_reg[12]; end
            2'h1: begin timer_b_cap_a <= level_reg[1]; timer_b_cap_b <= level_reg[2]; end
            default: begin timer_b_cap_a <= level_reg[15]; timer_b_cap_b <= level_reg[16]; end
        endcase
    end
end

endmodule

// File: tb/gpwm_board.sv
// Board-side model: port drivers, external sources and pull resistors
module gpwm_board (
    // Clock
    input wire logic clk_sys,
    // Port side
    input wire logic [16:0] pad_out,
    input wire logic [16:0] pad_oe,
    input wire logic [16:0] pad_pullup,
    input wire logic [16:0] pad_pulldown,
    output logic [16:0] pad_in,
    // Bench side
    input wire logic [16:0] ext_val,
    input wire logic [16:0] ext_en
);
    logic flip_reg = 1'b0;

    // ----------------------------------------
    // Pin level resolution
    // ----------------------------------------
    always_ff @(posedge clk_sys) begin
        flip_reg <= ~flip_reg;
    end

    // Port driver, then board source, then pull, else floating
    always_comb begin
        for (int i = 0; i < 17; i++) begin
            pad_in[i] = pad_oe[i] ? pad_out[i] : ext_en[i] ? ext_val[i] :
                pad_pullup[i] ? 1'b1 : pad_pulldown[i] ? 1'b0 : flip_reg;
        end
    end
endmodule

// File: tb/gpwm_port_asserts.sv
// Concurrent checks on the port's bus and pin behaviour
`include "gpwm_map.vh"

module gpwm_port_asserts (
    // Clock and reset
    input wire clk_sys,
    input wire sys_rst,
    // Bus
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [19:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    // Pins
    input wire [16:0] pad_in,
    input wire [16:0] pad_out,
    input wire [16:0] pad_oe,
    input wire deep_sleep,
    input wire [3:0] analog_in_sel
);
    localparam logic [19:0] A_OSL = {2'b00, `GPWM_IDX_OSET_LOW, 2'b00};
    localparam logic [19:0] A_OCL = {2'b00, `GPWM_IDX_OCLR_LOW, 2'b00};
    localparam logic [19:0] A_DSL = {2'b00, `GPWM_IDX_DSET_LOW, 2'b00};
    localparam logic [19:0] A_INL = {2'b00, `GPWM_IDX_IN_LOW, 2'b00};
    logic [16:0] pad_prev_reg;
    logic [3:0] stab_reg;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    // ----------------------------------------
    // Pin stability counter
    // ----------------------------------------
    always_ff @(posedge clk_sys) begin
        pad_prev_reg <= pad_in;
        if (sys_rst || pad_in != pad_prev_reg) begin
            stab_reg <= 4'h0;
        end else if (stab_reg != 4'hF) begin
            stab_reg <= stab_reg + 4'h1;
        end
    end

    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_wr(logic [19:0] a);
        psel && penable && pready && pwrite && paddr == a && !deep_sleep;
    endsequence

    a_ready_after_setup: assert property (s_setup |=> pready) else $error("no ready after setup");
    a_ready_pulse: assert property (pready |=> !pready) else $error("ready longer than one cycle");
    a_err_misalign: assert property (s_setup ##0 paddr[1:0] != 2'b00 |=> pslverr && pready)
        else $error("misaligned access not refused");
    a_rdata_quiet: assert property (!pready |-> prdata == 32'h0) else $error("read data outside access");
    a_input_read: assert property (s_setup ##0 !pwrite && paddr == A_INL && stab_reg > 4'h7
        |=> prdata[15:0] == $past(pad_in[15:0])) else $error("input read differs from pins");
    a_set_high: assert property (s_wr(A_OSL) |-> ##2
        (pad_out[15:0] & $past(pwdata[15:0], 2)) == $past(pwdata[15:0], 2)) else $error("set bits not high");
    a_clear_low: assert property (s_wr(A_OCL) |-> ##2
        (pad_out[15:0] & $past(pwdata[15:0], 2)) == 16'h0) else $error("cleared bits not low");
    a_drive_set: assert property (s_wr(A_DSL) |-> ##2
        (pad_oe[15:0] & $past(pwdata[15:0], 2)) == $past(pwdata[15:0], 2)) else $error("driver not enabled");
    a_freeze_hold: assert property (deep_sleep [*7] |-> $stable(pad_out) && $stable(pad_oe))
        else $error("pins moved in deep sleep");
    a_analog_off: assert property ((analog_in_sel & pad_oe[7:4]) == 4'h0)
        else $error("analog pin driven");
endmodule

bind gpwm_port gpwm_port_asserts i_chk (.clk_sys, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .pad_in, .pad_out, .pad_oe, .deep_sleep, .analog_in_sel);

// File: tb/gpwm_port_tb.sv
// Self-checking bench for the port
`include "gpwm_map.vh"

module gpwm_port_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'b0;
    logic sys_rst, psel, penable, pwrite, deep_sleep, trace_frame_enable, trace_serial_out;
    logic pready, pslverr, wake_req, vref_out_en, timer_a_cap_a, timer_b_cap_a, reg_en;
    logic [7:0] sdoe, sdin;
    logic [19:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [16:0] pad_in, pad_out, pad_oe, pad_pullup, pad_pulldown, ext_val, ext_en;
    logic [3:0] analog_in_sel, tmr;
    int fails = 0;
    int n_compared = 0;
    logic [63:0] rows [13] = '{
        {`GPWM_IDX_DEBUG, 16'h0000, `GPWM_IDX_ROUTING, 16'h2000},
        {`GPWM_IDX_OUT_LOW, 16'h00FF, `GPWM_IDX_OUT_LOW, 16'h00FF},
        {`GPWM_IDX_OSET_LOW, 16'h0F00, `GPWM_IDX_OUT_LOW, 16'h0FFF},
        {`GPWM_IDX_OCLR_LOW, 16'h00F0, `GPWM_IDX_OSET_LOW, 16'h0F0F},
        {`GPWM_IDX_OUT_HIGH, 16'h0001, `GPWM_IDX_OCLR_HIGH, 16'h0001},
        {`GPWM_IDX_DRV_LOW, 16'h0003, `GPWM_IDX_DRV_LOW, 16'h0003},
        {`GPWM_IDX_DSET_LOW, 16'h0100, `GPWM_IDX_DRV_LOW, 16'h0103},
        {`GPWM_IDX_DCLR_LOW, 16'h0001, `GPWM_IDX_DSET_LOW, 16'h0102},
        {`GPWM_IDX_PU_LOW, 16'h0004, `GPWM_IDX_PU_LOW, 16'h0004},
        {`GPWM_IDX_PD_HIGH, 16'h0001, `GPWM_IDX_PD_HIGH, 16'h0001},
        {`GPWM_IDX_ROUTING, 16'hFFFF, `GPWM_IDX_ROUTING, 16'h7FFF},
        {`GPWM_IDX_ROUTING, 16'h2000, `GPWM_IDX_ROUTING, 16'h2000},
        {`GPWM_IDX_WAKE_MASK, 16'h0001, `GPWM_IDX_WAKE_MASK, 16'h0001}
    };

    always #2.5 clk_sys = ~clk_sys;

    gpwm_port i_dut (
        .clk_sys, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .pad_in, .pad_out, .pad_oe, .pad_pullup, .pad_pulldown, .deep_sleep, .wake_req,
        .trace_frame_enable, .trace_serial_out, .regulator_enable(reg_en), .vref_drive(1'b0),
        .serial_dout(8'h00), .serial_doe(sdoe), .timer_b_compare_out_a(tmr[0]),
        .timer_b_compare_out_b(tmr[1]), .timer_a_compare_out_a(tmr[2]), .timer_a_compare_out_b(tmr[3]),
        .analog_in_sel, .vref_out_en, .serial_din(sdin), .timer_a_cap_a, .timer_a_cap_b(),
        .timer_b_cap_a, .timer_b_cap_b()
    );
    gpwm_board i_board (.clk_sys, .pad_out, .pad_oe, .pad_pullup, .pad_pulldown, .pad_in, .ext_val, .ext_en);

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic final_report();
        if (fails == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic apb(input logic [19:0] a, input logic wr, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            fails++;
            final_report();
        end
        rd = prdata;
        chk("pslverr", {31'h0, a[1:0] != 2'b00 || a[17:2] > `GPWM_IDX_CMP_ROUTE}, {31'h0, pslverr});
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [15:0] idx, input logic [15:0] d);
        apb({2'b00, idx, 2'b00}, 1'b1, {16'h0000, d});
    endtask

    task automatic rdc(input string nm, input logic [15:0] idx, input logic [15:0] e);
        apb({2'b00, idx, 2'b00}, 1'b0, 32'h0);
        chk(nm, {16'h0000, e}, rd);
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        int n;
        {sys_rst, psel, penable, pwrite, deep_sleep, trace_frame_enable, trace_serial_out} = 7'h40;
        {paddr, pwdata, tmr, sdoe, reg_en, ext_val, ext_en} = {20'h0, 32'h0, 4'h0, 8'h00, 1'b0, 17'h0, 17'h1FFFF};
        repeat (8) @(posedge clk_sys);
        sys_rst <= 1'b0;
        for (int i = 0; i < 13; i++) begin
            wr(rows[i][63:48], rows[i][47:32]);
            rdc("table", rows[i][31:16], rows[i][15:0]);
        end
        ext_en <= 17'h0FFFB;
        ext_val <= 17'h0A5A4;
        repeat (10) @(posedge clk_sys);
        rdc("in_low", `GPWM_IDX_IN_LOW, 16'hA5A4 | 16'h0106);
        rdc("in_high", `GPWM_IDX_IN_HIGH, 16'h0000);
        wr(`GPWM_IDX_ACTIVITY, 16'h0001);
        ext_val[5] <= 1'b0;
        repeat (10) @(posedge clk_sys);
        chk("wake_masked", 32'h0, {31'h0, wake_req});
        ext_val[0] <= 1'b1;
        n = 0;
        while (wake_req !== 1'b1 && n < 12) begin
            @(posedge clk_sys);
            n++;
        end
        chk("wake_req", 32'h1, {31'h0, wake_req});
        chk("capture", 32'h1, {31'h0, timer_a_cap_a});
        rdc("activity", `GPWM_IDX_ACTIVITY, 16'h0001);
        wr(`GPWM_IDX_ACTIVITY, 16'h0001);
        repeat (4) @(posedge clk_sys);
        chk("wake_clear", 32'h0, {31'h0, wake_req});
        wr(`GPWM_IDX_FREEZE, 16'h0001);
        deep_sleep <= 1'b1;
        repeat (10) @(posedge clk_sys);
        wr(`GPWM_IDX_OSET_LOW, 16'hF000);
        repeat (4) @(posedge clk_sys);
        chk("frozen", 32'h0F0F, {16'h0, pad_out[15:0]});
        deep_sleep <= 1'b0;
        wr(`GPWM_IDX_FREEZE, 16'h0000);
        repeat (10) @(posedge clk_sys);
        chk("thawed", 32'hFF0F, {16'h0, pad_out[15:0]});
        {trace_frame_enable, trace_serial_out} <= 2'b11;
        wr(`GPWM_IDX_ROUTING, 16'h6000);
        repeat (3) @(posedge clk_sys);
        chk("trace", 32'h3, {30'h0, pad_out[5:4]});
        wr(`GPWM_IDX_DSET_LOW, 16'h0010);
        wr(`GPWM_IDX_ROUTING, 16'h1000);
        repeat (3) @(posedge clk_sys);
        chk("analog", 32'h1, {28'h0, analog_in_sel});
        wr(`GPWM_IDX_ROUTING, 16'h2040);
        repeat (3) @(posedge clk_sys);
        chk("vref", 32'h1, {31'h0, vref_out_en});
        tmr <= 4'b0101;
        wr(`GPWM_IDX_CMP_ROUTE, 16'h000F);
        repeat (3) @(posedge clk_sys);
        chk("compare", 32'h5, {28'h0, pad_out[16:13]});
        {sdoe, reg_en} <= {8'hFF, 1'b1};
        wr(`GPWM_IDX_ROUTING, 16'h2142);
        repeat (8) @(posedge clk_sys);
        chk("serial_oe", 32'hFF, {24'h0, pad_oe[12:9], pad_oe[3:0]});
        chk("serial_din", 32'h0, {24'h0, sdin});
        chk("capture_alt", 32'h3, {30'h0, timer_b_cap_a, timer_a_cap_a});
        chk("regulator", 32'h4, {29'h0, pad_oe[7], pad_out[7], pad_out[8]});
        apb({2'b00, `GPWM_IDX_CMP_ROUTE + 16'h0002, 2'b00}, 1'b0, 32'h0);
        chk("unmapped", 32'h0, rd);
        apb({2'b00, `GPWM_IDX_OUT_LOW, 2'b10}, 1'b1, 32'h0);
        rdc("misalign", `GPWM_IDX_OUT_LOW, 16'hFF0F);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        chk("rst_pads", 32'h0, {15'h0, pad_out | pad_oe});
        sys_rst <= 1'b0;
        rdc("rst_routing", `GPWM_IDX_ROUTING, 16'h2000);
        final_report();
    end
endmodule
